// file: hw/fault_irq_map.svh
// register offsets, field positions, reset values and codes of the fault interrupt block
`ifndef FAULT_IRQ_MAP_SVH
`define FAULT_IRQ_MAP_SVH

// printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
`define SUPPLY_FLAGS_IDX     8'h0e
`define LED_ENABLES_IDX      8'h0c
`define SUPPLY_ENABLES_IDX   8'h40
`define IRQ_STATUS_IDX       8'h41
`define IRQ_CLEAR_IDX        8'h42
`define IRQ_ENABLE_IDX       8'h43

`define EN_GLOBAL_POS        6
`define EN_TIMEOUT_POS       4
`define EN_BADSTR_POS        2
`define EN_LEDFLT_POS        0
`define LED_ENABLES_RESET    16'h00aa
`define SUPPLY_ENABLES_RESET 16'haaaa
`define SUPPLY_FLAGS_RESET   16'h0000

`define EN_READ_ON           2'h2
`define EN_READ_OFF          2'h0
`define EN_WRITE_OFF         2'h1
`define EN_WRITE_ON          2'h3

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`define NUM_SUPPLY_FAULTS    8
`define NUM_EVENTS           3

`endif

// file: hw/fault_irq_pkg.sv
// types shared by the fault interrupt block
package fault_irq_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_t;

	typedef enum logic [2:0] {
		WR_IDLE = 3'b001,
		WR_TAKE = 3'b010,
		WR_RESP = 3'b100
	} wr_state_t;
endpackage : fault_irq_pkg

// file: hw/fault_irq_enable_and_supply_status.sv
// fault interrupt enables, supply fault flags and the interrupt output behind AXI4-Lite
// Behaviour
// - enable field reads 0h off, 2h on
// - write 1h disables, 3h enables field
// - global enable bits 7-6, resets on, gates all
// - timeout error enable bits 5-4, resets on
// - bad string enable bits 3-2, resets on
// - led fault enable bits 1-0, resets on
// - bits 15-8 reserved, reset zero, inert
// - supply flags reset zero, set on fault
// - clear needs flag and clear bit written
// - crc flag 15/14, sync flag 13/12
// - pump flag 11/10, cap flag 9/8
// - supply flags at 7,5,3,1, clears below
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fault_irq_map.svh"

module fault_irq_enable_and_supply_status (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  SUPPLY_FAULT_IN,
	input  wire logic        TIMEOUT_ERR_IN,
	input  wire logic        BAD_STRING_IN,
	input  wire logic        LED_FAULT_IN,
	input  wire logic [31:0] AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [31:0] ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic             IRQ
);

	fault_irq_pkg::wr_state_t wr_state_q;
	fault_irq_pkg::wr_req_t   wr_q;
	logic                     aw_have_q;
	logic                     w_have_q;
	logic [15:0]              led_en_q;
	logic [15:0]              sup_en_q;
	logic [7:0]               sup_flag_q;
	logic [2:0]               evt_status_q;
	logic [2:0]               evt_enable_q;
	logic                     wr_fire;
	logic [7:0]               wr_index;
	logic [15:0]              wr_lo;
	logic                     wr_lo_en;
	logic                     wr_hit;
	logic [7:0]               rd_index;
	logic [15:0]              sup_rd;
	logic [2:0]               events;
	logic                     irq_d;

	// write path: address and data taken in either order, response after both
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_state_q <= fault_irq_pkg::WR_IDLE;
			aw_have_q  <= 1'b0;
			w_have_q   <= 1'b0;
			wr_q       <= '0;
			AWREADY    <= 1'b0;
			WREADY     <= 1'b0;
			BVALID     <= 1'b0;
			BRESP      <= `RESP_OKAY;
		end else begin
			case (wr_state_q)
				fault_irq_pkg::WR_IDLE: begin
					AWREADY <= !aw_have_q && !(AWVALID && AWREADY);
					WREADY  <= !w_have_q && !(WVALID && WREADY);
					if (AWVALID && AWREADY) begin
						wr_q.addr <= AWADDR;
						aw_have_q <= 1'b1;
					end
					if (WVALID && WREADY) begin
						wr_q.data <= WDATA;
						wr_q.strb <= WSTRB;
						w_have_q  <= 1'b1;
					end
					if ((aw_have_q || (AWVALID && AWREADY)) &&
					    (w_have_q || (WVALID && WREADY))) begin
						AWREADY    <= 1'b0;
						WREADY     <= 1'b0;
						wr_state_q <= fault_irq_pkg::WR_TAKE;
					end
				end
				fault_irq_pkg::WR_TAKE: begin
					BVALID     <= 1'b1;
					BRESP      <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
					wr_state_q <= fault_irq_pkg::WR_RESP;
				end
				fault_irq_pkg::WR_RESP: begin
					if (BREADY) begin
						BVALID     <= 1'b0;
						aw_have_q  <= 1'b0;
						w_have_q   <= 1'b0;
						AWREADY    <= 1'b1;
						WREADY     <= 1'b1;
						wr_state_q <= fault_irq_pkg::WR_IDLE;
					end
				end
				default: wr_state_q <= fault_irq_pkg::WR_IDLE;
			endcase
		end
	end

	assign wr_fire  = (wr_state_q == fault_irq_pkg::WR_TAKE);
	assign wr_index = wr_q.addr[9:2];
	assign wr_lo    = wr_q.data[15:0];
	// enable and flag registers change only on a full low half-word write; irq clear and irq enable need lane 0 only
	assign wr_lo_en = wr_q.strb[0] && wr_q.strb[1] && wr_q.addr[1:0] == 2'h0;
	assign wr_hit   = wr_q.addr[31:10] == '0 && wr_q.addr[1:0] == 2'h0 &&
	                  (wr_index == `SUPPLY_FLAGS_IDX || wr_index == `LED_ENABLES_IDX ||
	                   wr_index == `SUPPLY_ENABLES_IDX || wr_index == `IRQ_STATUS_IDX ||
	                   wr_index == `IRQ_CLEAR_IDX || wr_index == `IRQ_ENABLE_IDX);

	// guarded enable fields: codes 0h and 2h on write leave the field alone
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_en
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					led_en_q[2*gi +: 2] <= 2'(`LED_ENABLES_RESET >> (2*gi));
					sup_en_q[2*gi +: 2] <= 2'(`SUPPLY_ENABLES_RESET >> (2*gi));
				end else if (wr_fire && wr_lo_en) begin
					if (wr_index == `LED_ENABLES_IDX && gi < 4) begin
						if (wr_lo[2*gi +: 2] == `EN_WRITE_OFF)
							led_en_q[2*gi +: 2] <= `EN_READ_OFF;
						else if (wr_lo[2*gi +: 2] == `EN_WRITE_ON)
							led_en_q[2*gi +: 2] <= `EN_READ_ON;
					end
					if (wr_index == `SUPPLY_ENABLES_IDX) begin
						if (wr_lo[2*gi +: 2] == `EN_WRITE_OFF)
							sup_en_q[2*gi +: 2] <= `EN_READ_OFF;
						else if (wr_lo[2*gi +: 2] == `EN_WRITE_ON)
							sup_en_q[2*gi +: 2] <= `EN_READ_ON;
					end
				end
			end
		end
	endgenerate

	// supply flag n sits at bit 2n+1, its clear at 2n; a new fault beats the clear
	generate
		for (gi = 0; gi < `NUM_SUPPLY_FAULTS; gi++) begin : g_flag
			always_ff @(posedge CLK or posedge RST) begin
				if (RST)
					sup_flag_q[gi] <= 1'b0;
				else if (SUPPLY_FAULT_IN[gi])
					sup_flag_q[gi] <= 1'b1;
				else if (wr_fire && wr_lo_en && wr_index == `SUPPLY_FLAGS_IDX &&
				         wr_lo[2*gi+1] && wr_lo[2*gi])
					sup_flag_q[gi] <= 1'b0;
			end
			assign sup_rd[2*gi+1] = sup_flag_q[gi];
			assign sup_rd[2*gi]   = 1'b0;
		end
	endgenerate

	// led-side events: sticky status, write-one clear register, set wins
	assign events = {LED_FAULT_IN, BAD_STRING_IN, TIMEOUT_ERR_IN};
	generate
		for (gi = 0; gi < `NUM_EVENTS; gi++) begin : g_evt
			always_ff @(posedge CLK or posedge RST) begin
				if (RST)
					evt_status_q[gi] <= 1'b0;
				else if (events[gi])
					evt_status_q[gi] <= 1'b1;
				else if (wr_fire && wr_q.strb[0] && wr_index == `IRQ_CLEAR_IDX && wr_lo[gi])
					evt_status_q[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			evt_enable_q <= 3'h7;
		else if (wr_fire && wr_q.strb[0] && wr_index == `IRQ_ENABLE_IDX)
			evt_enable_q <= wr_lo[2:0];
	end

	// interrupt: each source through its own enable, then the global gate
	always_comb begin
		irq_d = 1'b0;
		for (int i = 0; i < `NUM_SUPPLY_FAULTS; i++)
			irq_d = irq_d | (sup_flag_q[i] & sup_en_q[2*i+1]);
		irq_d = irq_d | (evt_status_q[0] & evt_enable_q[0] & led_en_q[`EN_TIMEOUT_POS+1]);
		irq_d = irq_d | (evt_status_q[1] & evt_enable_q[1] & led_en_q[`EN_BADSTR_POS+1]);
		irq_d = irq_d | (evt_status_q[2] & evt_enable_q[2] & led_en_q[`EN_LEDFLT_POS+1]);
		irq_d = irq_d & led_en_q[`EN_GLOBAL_POS+1];
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= irq_d;
	end

	// read path: one read in flight, answered the cycle after the address is taken
	assign rd_index = ARADDR[9:2];
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= `RESP_OKAY;
		end else if (RVALID) begin
			if (RREADY) begin
				RVALID  <= 1'b0;
				ARREADY <= 1'b1;
			end
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RRESP   <= `RESP_OKAY;
			RDATA   <= '0;
			if (ARADDR[31:10] != '0 || ARADDR[1:0] != 2'h0)
				RRESP <= `RESP_SLVERR;
			else case (rd_index)
				`SUPPLY_FLAGS_IDX:   RDATA <= {16'h0000, sup_rd};
				`LED_ENABLES_IDX:    RDATA <= {16'h0000, led_en_q};
				`SUPPLY_ENABLES_IDX: RDATA <= {16'h0000, sup_en_q};
				`IRQ_STATUS_IDX:     RDATA <= {29'h0, evt_status_q};
				`IRQ_CLEAR_IDX:      RDATA <= '0;
				`IRQ_ENABLE_IDX:     RDATA <= {29'h0, evt_enable_q};
				default:             RRESP <= `RESP_SLVERR;
			endcase
		end else begin
			ARREADY <= 1'b1;
		end
	end

	// write-side steps: clear pair in one write, flag left alone, write accepted
	sequence s_flag_clear_write(int n);
		wr_fire && wr_lo_en && wr_index == `SUPPLY_FLAGS_IDX && wr_lo[2*n+1] && wr_lo[2*n];
	endsequence

	sequence s_flag_left_alone(int n);
		sup_flag_q[n] && !SUPPLY_FAULT_IN[n] &&
		!(wr_fire && wr_lo_en && wr_index == `SUPPLY_FLAGS_IDX && wr_lo[2*n+1] && wr_lo[2*n]);
	endsequence

	sequence s_write_taken;
		wr_state_q == fault_irq_pkg::WR_TAKE;
	endsequence

	chk_enable_codes: assert property (@(posedge CLK) disable iff (RST)
		led_en_q[1:0] inside {2'h0, 2'h2} && led_en_q[7:6] inside {2'h0, 2'h2})
		else $error("enable field holds an illegal code");
	chk_write_off: assert property (@(posedge CLK) disable iff (RST)
		wr_fire && wr_lo_en && wr_index == `LED_ENABLES_IDX && wr_lo[7:6] == 2'h1
		|=> led_en_q[7:6] == 2'h0)
		else $error("disable code did not clear the global enable");
	chk_write_on: assert property (@(posedge CLK) disable iff (RST)
		wr_fire && wr_lo_en && wr_index == `LED_ENABLES_IDX && wr_lo[3:2] == 2'h3
		|=> led_en_q[3:2] == 2'h2)
		else $error("enable code did not set the string enable");
	chk_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
		led_en_q[15:8] == 8'h00)
		else $error("reserved enable bits not zero");
	chk_global_gate: assert property (@(posedge CLK) disable iff (RST)
		led_en_q[7:6] == 2'h0 |=> !IRQ)
		else $error("interrupt raised with global enable off");
	chk_flag_sticky: assert property (@(posedge CLK) disable iff (RST)
		SUPPLY_FAULT_IN[7] |=> sup_flag_q[7])
		else $error("supply fault not recorded");
	chk_clear_pair: assert property (@(posedge CLK) disable iff (RST)
		s_flag_left_alone(6) |=> sup_flag_q[6])
		else $error("supply flag dropped without paired clear");
	chk_clear_works: assert property (@(posedge CLK) disable iff (RST)
		s_flag_clear_write(0) ##0 !SUPPLY_FAULT_IN[0] |=> !sup_flag_q[0])
		else $error("paired clear did not clear the flag");
	chk_irq_follows: assert property (@(posedge CLK) disable iff (RST)
		sup_flag_q[3] && sup_en_q[7] && led_en_q[7] |=> IRQ)
		else $error("interrupt missing for enabled flag");
	chk_guard_ignored: assert property (@(posedge CLK) disable iff (RST)
		wr_fire && wr_lo_en && wr_index == `LED_ENABLES_IDX && wr_lo[5:4] == 2'h0
		|=> $stable(led_en_q[5:4]))
		else $error("ignored enable code changed the timeout enable");
	chk_irq_quiet: assert property (@(posedge CLK) disable iff (RST)
		sup_flag_q == 8'h00 && evt_status_q == 3'h0 |=> !IRQ)
		else $error("interrupt raised with nothing recorded");
	chk_event_sticky: assert property (@(posedge CLK) disable iff (RST)
		events[1] |=> evt_status_q[1])
		else $error("led-side event not recorded");
	chk_write_answer: assert property (@(posedge CLK) disable iff (RST)
		s_write_taken |=> BVALID)
		else $error("write taken but no response raised");
	chk_read_answer: assert property (@(posedge CLK) disable iff (RST)
		ARVALID && ARREADY && !RVALID |=> RVALID)
		else $error("read taken but no data returned");

endmodule : fault_irq_enable_and_supply_status

// file: testbench/tb_top.sv
// self-checking bench for the fault interrupt block
`timescale 1ns/1ps
`include "fault_irq_map.svh"

module tb_top;
	logic        CLK;
	logic        RST;
	logic [7:0]  SUPPLY_FAULT_IN;
	logic [2:0]  evt;
	logic [31:0] AWADDR;
	logic        AWVALID;
	logic        AWREADY;
	logic [31:0] WDATA;
	logic [3:0]  WSTRB;
	logic        WVALID;
	logic        WREADY;
	logic [1:0]  BRESP;
	logic        BVALID;
	logic        BREADY;
	logic [31:0] ARADDR;
	logic        ARVALID;
	logic        ARREADY;
	logic [31:0] RDATA;
	logic [1:0]  RRESP;
	logic        RVALID;
	logic        RREADY;
	logic        IRQ;
	logic [34:0] exp_q[$];
	logic [1:0]  bexp_q[$];
	logic [34:0] e;
	logic [31:0] seed;
	int          n_mismatch;
	int          cmp_count;

	fault_irq_enable_and_supply_status i_dut (
		.CLK(CLK), .RST(RST), .SUPPLY_FAULT_IN(SUPPLY_FAULT_IN),
		.TIMEOUT_ERR_IN(evt[0]), .BAD_STRING_IN(evt[1]), .LED_FAULT_IN(evt[2]),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// master holds bready from the start, as the bus allows; the monitor checks bresp
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge CLK);
		bexp_q.push_back(r);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (k = 0; k < 40 && BVALID !== 1'b1; k++) begin
			@(posedge CLK);
			if (AWREADY === 1'b1) AWVALID <= 1'b0;
			if (WREADY === 1'b1) WVALID <= 1'b0;
		end
		if (k == 40) begin
			n_mismatch++;
			wrap_up();
		end else begin
			BREADY <= 1'b0;
		end
	endtask : wr

	// expectation goes on the queue; the monitor compares it
	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge CLK);
		exp_q.push_back({r == `RESP_SLVERR, r, d});
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (k = 0; k < 40 && RVALID !== 1'b1; k++) begin
			@(posedge CLK);
			if (ARREADY === 1'b1) ARVALID <= 1'b0;
		end
		if (k == 40) begin
			n_mismatch++;
			wrap_up();
		end else begin
			RREADY <= 1'b0;
		end
	endtask : rd

	// irq lags the register update by one edge; three edges is ample
	task automatic irq_is(input logic x);
		repeat (3) @(posedge CLK);
		#1 chk("irq", {31'h0, IRQ}, {31'h0, x});
	endtask : irq_is

	always @(posedge CLK) begin
		if (RVALID === 1'b1 && RREADY === 1'b1) begin
			if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				chk("rresp", {30'h0, RRESP}, {30'h0, e[33:32]});
				if (!e[34]) chk("rdata", RDATA, e[31:0]);
			end else begin
				chk("unexpected rvalid", 32'h1, 32'h0);
			end
		end
		if (BVALID === 1'b1 && BREADY === 1'b1) begin
			if (bexp_q.size() > 0)
				chk("bresp", {30'h0, BRESP}, {30'h0, bexp_q.pop_front()});
			else
				chk("unexpected bvalid", 32'h1, 32'h0);
		end
	end

	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	initial begin
		RST = 1'b1;
		{SUPPLY_FAULT_IN, evt, AWADDR, WDATA, ARADDR} = '0;
		WSTRB = 4'hf;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		seed = 32'hc8db;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		rd(32'h30, {16'h0, `LED_ENABLES_RESET}, `RESP_OKAY);
		rd(32'h38, 32'h0, `RESP_OKAY);
		rd(32'h10c, 32'h7, `RESP_OKAY);
		// random junk in the reserved byte must leave the fields alone
		for (int p = 0; p < 8; p += 2) begin
			seed = xs(seed);
			wr(32'h30, {16'h0, seed[15:8], 8'h0} | (32'(`EN_WRITE_OFF) << p), `RESP_OKAY);
			rd(32'h30, 32'haa & ~(32'h3 << p), `RESP_OKAY);
			wr(32'h30, {16'h0, seed[23:16], 8'h0} | (32'(`EN_WRITE_ON) << p), `RESP_OKAY);
			rd(32'h30, 32'haa, `RESP_OKAY);
		end
		for (int n = 0; n < 8; n++) begin
			@(posedge CLK);
			SUPPLY_FAULT_IN <= 8'h1 << n;
			@(posedge CLK);
			SUPPLY_FAULT_IN <= 8'h0;
			irq_is(1'b1);
			rd(32'h38, 32'h2 << (2 * n), `RESP_OKAY);
			wr(32'h38, 32'h2 << (2 * n), `RESP_OKAY);
			wr(32'h38, 32'h1 << (2 * n), `RESP_OKAY);
			rd(32'h38, 32'h2 << (2 * n), `RESP_OKAY);
			irq_is(1'b1);
			if (n == 0) begin
				wr(32'h30, 32'h40, `RESP_OKAY);
				irq_is(1'b0);
				wr(32'h30, 32'hc0, `RESP_OKAY);
				irq_is(1'b1);
			end
			wr(32'h38, 32'h3 << (2 * n), `RESP_OKAY);
			rd(32'h38, 32'h0, `RESP_OKAY);
			irq_is(1'b0);
		end
		// timeout, bad string, led fault map to fields 5-4, 3-2, 1-0
		for (int i = 0; i < 3; i++) begin
			@(posedge CLK);
			evt <= 3'h1 << i;
			@(posedge CLK);
			evt <= 3'h0;
			irq_is(1'b1);
			rd(32'h104, 32'h1 << i, `RESP_OKAY);
			wr(32'h30, 32'h1 << (4 - 2 * i), `RESP_OKAY);
			irq_is(1'b0);
			wr(32'h30, 32'h3 << (4 - 2 * i), `RESP_OKAY);
			irq_is(1'b1);
			wr(32'h108, 32'h1 << i, `RESP_OKAY);
			irq_is(1'b0);
		end
		// partial lanes must leave the enables alone
		WSTRB <= 4'h1;
		wr(32'h30, 32'h40, `RESP_OKAY);
		WSTRB <= 4'hf;
		rd(32'h30, 32'haa, `RESP_OKAY);
		// per-flag supply enable and per-event enable gate the interrupt
		wr(32'h100, 32'h1, `RESP_OKAY);
		rd(32'h100, 32'haaa8, `RESP_OKAY);
		@(posedge CLK);
		SUPPLY_FAULT_IN <= 8'h01;
		@(posedge CLK);
		SUPPLY_FAULT_IN <= 8'h00;
		irq_is(1'b0);
		wr(32'h100, 32'h3, `RESP_OKAY);
		irq_is(1'b1);
		wr(32'h38, 32'h3, `RESP_OKAY);
		irq_is(1'b0);
		wr(32'h10c, 32'h6, `RESP_OKAY);
		@(posedge CLK);
		evt <= 3'h1;
		@(posedge CLK);
		evt <= 3'h0;
		irq_is(1'b0);
		rd(32'h104, 32'h1, `RESP_OKAY);
		wr(32'h10c, 32'h7, `RESP_OKAY);
		irq_is(1'b1);
		wr(32'h108, 32'h1, `RESP_OKAY);
		rd(32'h108, 32'h0, `RESP_OKAY);
		irq_is(1'b0);
		rd(32'h200, 32'h0, `RESP_SLVERR);
		wr(32'h200, 32'hffff, `RESP_SLVERR);
		rd(32'h30, 32'haa, `RESP_OKAY);
		repeat (4) @(posedge CLK);
		chk("pending answers", 32'(exp_q.size() + bexp_q.size()), 32'h0);
		wrap_up();
	end
endmodule : tb_top
